// File: bccr_top.sv
// buck channel configuration register and the channel controls it steers
// register port:
//   a write is taken at a rising edge with the strobe high and a matching address
//   writes to any other address are ignored; writes may follow back to back
//   readback is registered, so read data follow the address by one cycle
//   unmapped addresses read back zero
// fault path:
//   fault, short and soft-start-done pins are asynchronous, two flip-flops each
//   the sticky fault flag sets three cycles after the fault or short pin rises
//   a config write clears the flag, but a fault in the same cycle wins
//   the interrupt is registered from the next flag and the next mask,
//   so a mask write takes effect on the edge at which it lands
// short-circuit response:
//   a short only counts while the channel is enabled, so an idle channel
//   cannot trip a global shutdown
//   retry on: the channel pauses, then raises soft start and waits for the
//   power stage to report completion; a short still present starts a new pause
//   the channel stays in this loop for as long as the short remains
//   retry off: every channel drops for the restart count, then run resumes
//   the restart count is a parameter worth 100 ms at the 125 MHz clock;
//   a bench may shorten it, silicon should keep the default
//   the pause and the restart share one counter, as only one runs at a time
// enables and modes:
//   the override select picks the register enable over the mode-register enable
//   the drain follows the channel: it is on whenever the channel is off
//   and the drain bit is set, soft-start pauses included
//   phase, ramp rate and mode bits drive their outputs straight from flip-flops
//   limitation: only the active-mode register is modelled here; the low-power
//   mode registers live elsewhere and do not steer this channel
`timescale 1ns/1ps
`include "bccr_cfg.svh"
module bccr_top
  import bccr_pkg::*;
#(
  parameter int RESTART_CYC = `BCCR_RESTART_CYC
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // register port from the serial bus engine
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // analog status pins
  input wire logic short_i,
  input wire logic fault_i,
  input wire logic softstart_done_i,
  // channel controls
  output logic channel_on_o,
  output logic softstart_o,
  output logic all_off_o,
  output logic output_drain_o,
  output logic phase_shift_o,
  output logic [1:0] voltage_ramp_rate_sel_o,
  output logic forced_fixed_freq_switching_o,
  output logic channel_fault_flag_o,
  output logic irq_out_n_o
);
  // all state in one record; the counter serves both the pause and the restart
  typedef struct packed
  {
    logic [7:0] cfg;
    logic [7:0] act;
    logic [7:0] rdata;
    logic fault_flag;
    logic irq_n;
    logic ss;
    logic [31:0] cnt;
    bccr_state_t st;
  } bccr_top_t;
  bccr_top_t r;
  bccr_top_t next_r;
  // synchronised pin levels and decoded controls
  logic short_s;
  logic fault_s;
  logic ssdone_s;
  logic ch_en;
  logic cfg_wr;
  logic act_wr;
  // pins from the analog side are asynchronous
  bccr_sync u_sync_short
  (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .d_i(short_i),
    .q_o(short_s)
  );
  bccr_sync u_sync_fault
  (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .d_i(fault_i),
    .q_o(fault_s)
  );
  bccr_sync u_sync_ss
  (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .d_i(softstart_done_i),
    .q_o(ssdone_s)
  );
  // enable choice: override select picks the register bit
  assign ch_en = r.cfg[`BCCR_BIT_OVSEL] ? r.cfg[`BCCR_BIT_REGEN] : r.act[`BCCR_ACT_BIT_EN];
  // write decodes, shared by the register loads and the flag clear
  assign cfg_wr = wr_en_i && (addr_i == `BCCR_CFG_ADDR);
  assign act_wr = wr_en_i && (addr_i == `BCCR_ACT_ADDR);
  // next state: register loads, fault flag and short-circuit response
  always_comb
  begin
    next_r = r;
    // register writes and registered readback
    if (cfg_wr)
    begin
      next_r.cfg = wdata_i;
    end
    if (act_wr)
    begin
      next_r.act = wdata_i;
    end
    unique case (addr_i)
      `BCCR_CFG_ADDR: next_r.rdata = r.cfg;
      `BCCR_ACT_ADDR: next_r.rdata = r.act;
      default: next_r.rdata = 8'h00;
    endcase
    // sticky fault flag: a config write clears it, a fault in the same cycle wins
    next_r.fault_flag = fault_s | short_s | (r.fault_flag & ~cfg_wr);
    // interrupt low only for an unmasked fault
    next_r.irq_n = ~(next_r.fault_flag & ~next_r.cfg[`BCCR_BIT_FLTMASK]);
    // short circuit response
    unique case (r.st)
      BCCR_RUN:
      begin
        next_r.ss = 1'b0;
        // an idle channel cannot trip the short response
        if (short_s && ch_en)
        begin
          next_r.cnt = '0;
          if (r.cfg[`BCCR_BIT_RETRY])
          begin
            next_r.st = BCCR_HICCUP;
          end
          else
          begin
            next_r.st = BCCR_SHUT;
          end
        end
      end
      BCCR_HICCUP:
      begin
        // unlimited retries: off for a pause, then soft start again
        next_r.cnt = r.cnt + 32'h0000_0001;
        next_r.ss = r.cnt >= 32'(`BCCR_RETRY_CYC);
        if (r.ss && ssdone_s)
        begin
          next_r.cnt = '0;
          next_r.st = short_s ? BCCR_HICCUP : BCCR_RUN;
          next_r.ss = 1'b0;
        end
      end
      BCCR_SHUT:
      begin
        // every channel held off for the restart count
        next_r.ss = 1'b0;
        next_r.cnt = r.cnt + 32'h0000_0001;
        if (r.cnt >= 32'(RESTART_CYC - 1))
        begin
          next_r.cnt = '0;
          next_r.st = BCCR_RUN;
        end
      end
      default:
      begin
        // an illegal code falls back to run rather than locking up
        next_r.st = BCCR_RUN;
      end
    endcase
  end
  // synchronous reset loads the power-on values
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      r.cfg <= `BCCR_CFG_RESET;
      r.act <= `BCCR_ACT_RESET;
      r.rdata <= 8'h00;
      r.fault_flag <= 1'b0;
      r.irq_n <= 1'b1;
      r.ss <= 1'b0;
      r.cnt <= '0;
      r.st <= BCCR_RUN;
    end
    else
    begin
      r <= next_r;
    end
  end
  // register readback
  assign rdata_o = r.rdata;
  // channel state
  assign channel_on_o = ch_en && (r.st == BCCR_RUN || r.ss);
  assign softstart_o = r.ss;
  assign all_off_o = (r.st == BCCR_SHUT);
  assign output_drain_o = r.cfg[`BCCR_BIT_DRAIN] && !channel_on_o;
  // config fields straight from flip-flops
  assign phase_shift_o = r.cfg[`BCCR_BIT_PHASE];
  assign voltage_ramp_rate_sel_o = r.cfg[`BCCR_RATE_HI:`BCCR_RATE_LO];
  assign forced_fixed_freq_switching_o = r.act[`BCCR_ACT_BIT_MODE];
  // fault status
  assign channel_fault_flag_o = r.fault_flag;
  assign irq_out_n_o = r.irq_n;
endmodule : bccr_top

// File: bccr_cfg.svh
// register offsets, field positions, reset values and timing counts for the buck channel config block
`ifndef BCCR_CFG_SVH
`define BCCR_CFG_SVH
`define BCCR_CFG_ADDR 8'h35
`define BCCR_ACT_ADDR 8'h41
`define BCCR_BIT_FLTMASK 7
`define BCCR_BIT_RETRY 6
`define BCCR_BIT_DRAIN 5
`define BCCR_BIT_PHASE 4
`define BCCR_RATE_HI 3
`define BCCR_RATE_LO 2
`define BCCR_BIT_REGEN 1
`define BCCR_BIT_OVSEL 0
`define BCCR_ACT_BIT_EN 7
`define BCCR_ACT_BIT_MODE 6
`define BCCR_CFG_RESET 8'hB0
`define BCCR_ACT_RESET 8'hFD
`define BCCR_RESTART_MS 100
`define BCCR_CLK_KHZ 125000
`define BCCR_RESTART_CYC (`BCCR_RESTART_MS * `BCCR_CLK_KHZ)
`define BCCR_RETRY_CYC 16'h0400
`endif

// File: bccr_pkg.sv
// types for the buck channel config block
package bccr_pkg;
  typedef enum logic [2:0]
  {
    BCCR_RUN = 3'b001,
    BCCR_HICCUP = 3'b010,
    BCCR_SHUT = 3'b100
  } bccr_state_t;
endpackage : bccr_pkg

// File: bccr_sync.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module bccr_sync
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // level in and out
  input wire logic d_i,
  output logic q_o
);
  typedef struct packed
  {
    logic s1;
    logic s2;
  } bccr_sync_t;
  bccr_sync_t r;
  bccr_sync_t next_r;
  // first stage feeds only the second
  always_comb
  begin
    next_r.s1 = d_i;
    next_r.s2 = r.s1;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end
  assign q_o = r.s2;
endmodule : bccr_sync

// File: bccr_top_checker.sv
// port assertions for the buck channel config block
`timescale 1ns/1ps
module bccr_top_checker
(
  // clock, reset and register port
  input logic sys_clk_i,
  input logic nrst_i,
  input logic wr_en_i,
  input logic [7:0] addr_i,
  input logic [7:0] wdata_i,
  // channel outputs
  input logic softstart_o,
  input logic all_off_o,
  input logic channel_on_o,
  input logic output_drain_o,
  input logic phase_shift_o,
  input logic [1:0] voltage_ramp_rate_sel_o,
  input logic forced_fixed_freq_switching_o,
  input logic channel_fault_flag_o,
  input logic irq_out_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // write decodes, mirrored from the port
  wire cw = wr_en_i && addr_i == 8'h35;
  wire aw = wr_en_i && addr_i == 8'h41;
  logic mask_sh;
  logic drain_sh;
  // shadow copies of the mask and drain bits, loaded as a host write lands
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      mask_sh <= 1'b1;
      drain_sh <= 1'b1;
    end
    else if (cw)
    begin
      mask_sh <= wdata_i[7];
      drain_sh <= wdata_i[5];
    end
  end
  chk_ramp_load: assert property (cw |=> voltage_ramp_rate_sel_o == $past(wdata_i[3:2]))
    else $error("ramp rate not loaded");
  chk_phase_load: assert property (cw |=> phase_shift_o == $past(wdata_i[4]))
    else $error("phase not loaded");
  chk_mode_load: assert property (aw |=> forced_fixed_freq_switching_o == $past(wdata_i[6]))
    else $error("mode not loaded");
  chk_drain_off: assert property (output_drain_o == (drain_sh && !channel_on_o))
    else $error("drain does not follow bit and channel");
  chk_shut_all: assert property ($rose(all_off_o) |-> !channel_on_o [*8])
    else $error("channel on in shutdown");
  chk_retry_local: assert property (softstart_o |-> !all_off_o)
    else $error("retry shut all");
  chk_irq_cause: assert property (!irq_out_n_o |-> channel_fault_flag_o)
    else $error("irq without fault");
  chk_reset_load: assert property ($rose(nrst_i) |-> phase_shift_o && voltage_ramp_rate_sel_o == 2'h0)
    else $error("reset values wrong");
  chk_irq_mask: assert property (irq_out_n_o == !(channel_fault_flag_o && !mask_sh))
    else $error("interrupt disagrees with mask and flag");
  chk_fault_sticky: assert property (channel_fault_flag_o && !cw |=> channel_fault_flag_o)
    else $error("fault flag dropped without a config write");
  cover property (softstart_o);
  cover property (all_off_o);
  cover property (!irq_out_n_o);
endmodule : bccr_top_checker
bind bccr_top bccr_top_checker chk_u (.*);

// File: bccr_pwr_model.sv
// power stage model answering soft-start requests
`timescale 1ns/1ps
module bccr_pwr_model
(
  // clock
  input logic sys_clk_i,
  // soft-start request and completion
  input logic softstart_i,
  output logic softstart_done_o
);
  logic [2:0] ramp_cnt = 3'h0;
  // slow ramp so the retry state is seen for several cycles; done holds until the request drops
  always @(posedge sys_clk_i)
    ramp_cnt <= !softstart_i ? 3'h0 : ((&ramp_cnt) ? ramp_cnt : ramp_cnt + 3'h1);
  assign softstart_done_o = &ramp_cnt;
endmodule : bccr_pwr_model

// File: bccr_top_tb.sv
// self-checking bench for the buck channel config block
`timescale 1ns/1ps
module bccr_top_tb;
  logic sys_clk_i = 0, nrst_i = 0, wr_en_i = 0, short_i = 0, fault_i = 0, sd, on, ss, off, dr, ph, ff, fl, irq_n;
  logic [7:0] addr_i = 0, wdata_i = 0, rdata_o;
  logic [1:0] rr;
  int err_total = 0, checks = 0;
  initial forever #4 sys_clk_i = ~sys_clk_i;
  // short restart count keeps the run brief
  bccr_top #(.RESTART_CYC(50)) dut_u (.sys_clk_i, .nrst_i, .wr_en_i, .addr_i, .wdata_i, .rdata_o, .short_i,
    .fault_i, .softstart_done_i(sd), .channel_on_o(on), .softstart_o(ss), .all_off_o(off), .output_drain_o(dr),
    .phase_shift_o(ph), .voltage_ramp_rate_sel_o(rr), .forced_fixed_freq_switching_o(ff),
    .channel_fault_flag_o(fl), .irq_out_n_o(irq_n));
  bccr_pwr_model pm_u (.sys_clk_i, .softstart_i(ss), .softstart_done_o(sd));
  task automatic chk(string n, logic [7:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, d);
    @(posedge sys_clk_i);
    wr_en_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_en_i <= 0;
    @(negedge sys_clk_i);
  endtask : wr
  task automatic rd(string n, logic [7:0] a, exp);
    @(posedge sys_clk_i);
    addr_i <= a;
    repeat (2) @(negedge sys_clk_i);
    chk(n, rdata_o, exp);
  endtask : rd
  // bounded wait, a timeout closes the run
  task automatic wt(ref logic s);
    int i;
    for (i = 0; i < 2000 && s !== 1; i++) @(negedge sys_clk_i);
    if (i == 2000)
    begin
      err_total++;
      final_report();
    end
  endtask : wt
  task automatic final_report;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    nrst_i <= 1;
    rd("cfg", 8'h35, 8'hB0);
    rd("gap", 8'h00, 8'h00);
    wr(8'h35, 8'h0C);
    chk("rate", rr, 3);
    chk("ph", ph, 0);
    wr(8'h35, 8'h13);
    chk("on", on, 1);
    chk("ph", ph, 1);
    wr(8'h41, 8'h3D);
    chk("ff", ff, 0);
    rd("act", 8'h41, 8'h3D);
    chk("on", on, 1);
    wr(8'h35, 8'h20);
    chk("on", on, 0);
    chk("dr", dr, 1);
    @(posedge sys_clk_i) fault_i <= 1;
    repeat (6) @(negedge sys_clk_i);
    chk("irq", irq_n, 0);
    @(posedge sys_clk_i) fault_i <= 0;
    repeat (4) @(posedge sys_clk_i);
    wr(8'h85, 8'h00);
    rd("cfg", 8'h35, 8'h20);
    wr(8'h35, 8'h80);
    chk("dr", dr, 0);
    chk("fl", fl, 0);
    chk("irq", irq_n, 1);
    @(posedge sys_clk_i) fault_i <= 1;
    repeat (6) @(negedge sys_clk_i);
    chk("fl", fl, 1);
    chk("irq", irq_n, 1);
    wr(8'h41, 8'hFD);
    chk("ff", ff, 1);
    wr(8'h35, 8'hE0);
    @(posedge sys_clk_i) short_i <= 1;
    wt(ss);
    chk("on", on, 1);
    chk("off", off, 0);
    @(posedge sys_clk_i) short_i <= 0;
    repeat (30) @(posedge sys_clk_i);
    wr(8'h35, 8'hA0);
    @(posedge sys_clk_i) short_i <= 1;
    wt(off);
    @(posedge sys_clk_i) short_i <= 0;
    repeat (40) @(negedge sys_clk_i);
    chk("off", off, 1);
    repeat (20) @(negedge sys_clk_i);
    chk("off", off, 0);
    chk("on", on, 1);
    final_report();
  end
endmodule : bccr_top_tb
